/* smc_pkg.sv */
// package of constants for the static memory read/write waveform generator
package smc_pkg;

  // ----------------------------------------------------------------
  // interface geometry
  // ----------------------------------------------------------------
  localparam int NUM_CS     = 4;
  localparam int ADDR_W     = 26;
  localparam int DATA_W     = 32;
  localparam int CNT_W      = 10;

  // ----------------------------------------------------------------
  // timing field layout
  // ----------------------------------------------------------------
  localparam int SETUP_W    = 6;
  localparam int PULSE_W    = 7;
  localparam int CYCLE_W    = 9;
  localparam int SETUP_HI   = 128;
  localparam int PULSE_HI   = 256;
  localparam int CYCLE_HI   = 256;
  // positions of each setup/pulse/cycle field inside its per-chip-select word
  localparam int NRD_POS    = 0;
  localparam int CSRD_POS   = 1;
  localparam int NWE_POS    = 2;
  localparam int CSWR_POS   = 3;
  localparam int RDCYC_POS  = 0;
  localparam int WRCYC_POS  = 1;

  // ----------------------------------------------------------------
  // data bus width codes
  // ----------------------------------------------------------------
  localparam logic [1:0] DBW_8  = 2'h0;
  localparam logic [1:0] DBW_16 = 2'h1;
  localparam logic [1:0] DBW_32 = 2'h2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] CNT_RST = 10'h000;

  // ----------------------------------------------------------------
  // controller states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SMC_IDLE  = 3'b001,
    SMC_READ  = 3'b010,
    SMC_WRITE = 3'b100
  } smc_state_t;

endpackage : smc_pkg

/* smc_edge_gen.sv */
// one strobe generator: low between setup and setup+pulse of the cycle counter
`timescale 1ns/1ps
module smc_edge_gen
  import smc_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // cycle position
  input  wire logic             active,
  input  wire logic             last,
  input  wire logic [CNT_W-1:0] cnt,
  input  wire logic [CNT_W-1:0] setup,
  input  wire logic [CNT_W-1:0] pulse,
  input  wire logic             next_same,
  // strobe
  output logic                  strobe_n,
  output logic                  rise
);
  logic             nxt_low;
  logic             strobe_n_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic [CNT_W-1:0] edge_end;

  // ----------------------------------------------------------------
  // strobe window
  // ----------------------------------------------------------------
  // counter value one cycle ahead, so the strobe flop lines up with it
  assign nxt_cnt  = last ? CNT_RST : cnt + 10'h001;
  assign edge_end = setup + pulse;
  // next_same flags a taken access with null setup: the strobe then falls in its cycle 0
  assign nxt_low  = next_same || (active && !last && nxt_cnt >= setup && nxt_cnt < edge_end);
  // rising edge is made on the clock where the strobe is low and leaves the window
  assign rise     = active && !strobe_n_ff && (cnt + 10'h001 == edge_end);

  // strobe register, inactive high at reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strobe_n_ff <= 1'b1;
    end else begin
      strobe_n_ff <= !nxt_low;
    end
  end

  assign strobe_n = strobe_n_ff;

endmodule : smc_edge_gen

/* smc_core.sv */
// static memory controller read/write waveform engine for four chip selects
`timescale 1ns/1ps
// How it works
// - byte selects load with the address on each take, go high after the last cycle, and stay high in byte write mode.
// - each of four byte write strobes copies the write strobe timing.
// - address drives all bits for 8-bit, drops A0 for 16-bit, A1:A0 for 32-bit.
// - read strobe falls after setup, stays low for pulse, address held after.
// - read chip select has its own setup, pulse and hold counts.
// - read lasts programmed total; holds are total minus setup and pulse.
// - every timing is per chip select, in whole clock cycles.
// - zero setup and hold keeps read strobes low across back-to-back reads.
// - a per-chip-select read mode bit alone picks the capture signal.
// - read mode 1 captures data on the clock raising the read strobe.
// - read mode 0 captures data on the clock raising the chip select.
// - write strobe falls after setup, low for pulse, data held after.
// - write chip select uses counts separate from the read ones.
// - write lasts programmed total; holds are total minus setup and pulse.
// - zero write setup and hold keeps strobes low across back-to-back writes.
// - write mode 1 turns data drivers on after write strobe setup.
// - write mode 0 turns data drivers on after write chip select setup.
// - each chip select has a setup, a pulse and a cycle register.
// - setup is 6 bits, worth 128 times top bit plus low five.
// - pulse is 7 bits, worth 256 times top bit plus low six.
// - cycle is 9 bits, worth 256 times top two bits plus low seven.
// - four active-low chip selects, active-low read and write strobes.
module smc_core
  import smc_pkg::*;
(
  // clock and reset
  input  wire logic                                clk,
  input  wire logic                                rst,
  // per chip select timing words
  input  wire logic [NUM_CS-1:0][4*SETUP_W-1:0]    setup_cfg,
  input  wire logic [NUM_CS-1:0][4*PULSE_W-1:0]    pulse_cfg,
  input  wire logic [NUM_CS-1:0][2*CYCLE_W-1:0]    cycle_cfg,
  // per chip select mode bits
  input  wire logic [NUM_CS-1:0]                   read_mode,
  input  wire logic [NUM_CS-1:0]                   write_mode,
  input  wire logic [NUM_CS-1:0]                   byte_write_mode,
  input  wire logic [NUM_CS-1:0][1:0]              bus_width,
  // access request
  input  wire logic                                req_valid,
  output logic                                     req_ready,
  input  wire logic                                req_write,
  input  wire logic [1:0]                          req_cs,
  input  wire logic [ADDR_W-1:0]                   req_addr,
  input  wire logic [3:0]                          req_byte_en,
  input  wire logic [DATA_W-1:0]                   req_wdata,
  // read answer
  output logic                                     rd_valid,
  output logic [DATA_W-1:0]                        rd_data,
  // memory pins
  output logic [ADDR_W-1:0]                        mem_addr,
  output logic [NUM_CS-1:0]                        chip_select_n,
  output logic                                     read_strobe_n,
  output logic                                     write_strobe_n,
  output logic                                     byte0_write_strobe_n,
  output logic                                     byte1_write_strobe_n,
  output logic                                     byte2_write_strobe_n,
  output logic                                     byte3_write_strobe_n,
  output logic                                     byte0_select_n,
  output logic                                     byte1_select_n,
  output logic                                     byte2_select_n,
  output logic                                     byte3_select_n,
  input  wire logic [DATA_W-1:0]                   mem_data_in,
  output logic [DATA_W-1:0]                        mem_data_out,
  output logic                                     mem_data_oe
);
  import smc_pkg::*;

  // ----------------------------------------------------------------
  // field decoders
  // ----------------------------------------------------------------
  function automatic logic [CNT_W-1:0] dec_setup(input logic [SETUP_W-1:0] f);
    dec_setup = (f[5] ? CNT_W'(SETUP_HI) : CNT_W'(0)) + CNT_W'(f[4:0]);
  endfunction : dec_setup

  function automatic logic [CNT_W-1:0] dec_pulse(input logic [PULSE_W-1:0] f);
    dec_pulse = (f[6] ? CNT_W'(PULSE_HI) : CNT_W'(0)) + CNT_W'(f[5:0]);
  endfunction : dec_pulse

  function automatic logic [CNT_W-1:0] dec_cycle(input logic [CYCLE_W-1:0] f);
    dec_cycle = CNT_W'(f[8:7]) * CNT_W'(CYCLE_HI) + CNT_W'(f[6:0]);
  endfunction : dec_cycle

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  smc_state_t          state_ff, nxt_state;
  logic [CNT_W-1:0]    cnt_ff, nxt_cnt;
  logic [1:0]          cs_ff;
  logic                wr_ff;
  logic [3:0]          ben_ff;
  logic [ADDR_W-1:0]   addr_ff;
  logic [DATA_W-1:0]   wdata_ff;
  logic [DATA_W-1:0]   rdata_ff;
  logic                rd_valid_ff;
  logic                oe_ff;
  logic [3:0]          bsel_n_ff;

  // ----------------------------------------------------------------
  // timing selection for the access in flight
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] st_setup, st_pulse, cs_setup, cs_pulse, total;
  logic             active, last, take, st_start_low, cs_start_low;
  logic             st_rise, cs_rise, st_low_n, cs_low_n;

  // the in-flight chip select picks its own set; reads and writes use separate fields
  assign st_setup = dec_setup(setup_cfg[cs_ff][(wr_ff ? NWE_POS : NRD_POS)*SETUP_W +: SETUP_W]);
  assign cs_setup = dec_setup(setup_cfg[cs_ff][(wr_ff ? CSWR_POS : CSRD_POS)*SETUP_W +: SETUP_W]);
  assign st_pulse = dec_pulse(pulse_cfg[cs_ff][(wr_ff ? NWE_POS : NRD_POS)*PULSE_W +: PULSE_W]);
  assign cs_pulse = dec_pulse(pulse_cfg[cs_ff][(wr_ff ? CSWR_POS : CSRD_POS)*PULSE_W +: PULSE_W]);
  assign total    = dec_cycle(cycle_cfg[cs_ff][(wr_ff ? WRCYC_POS : RDCYC_POS)*CYCLE_W +: CYCLE_W]);

  // hold phases fall out of the total: the access ends at total-1, whatever setup+pulse is
  assign active    = (state_ff != SMC_IDLE);
  assign last      = active && (cnt_ff + 10'h001 >= total);
  assign req_ready = !active || last;
  assign take      = req_valid && req_ready;
  // a taken access with null setup starts low at once, also from idle, so no gap appears
  logic [CNT_W-1:0] new_st_setup, new_cs_setup;
  assign new_st_setup = dec_setup(setup_cfg[req_cs][(req_write ? NWE_POS : NRD_POS)*SETUP_W +: SETUP_W]);
  assign new_cs_setup = dec_setup(setup_cfg[req_cs][(req_write ? CSWR_POS : CSRD_POS)*SETUP_W +: SETUP_W]);
  assign st_start_low = take && (new_st_setup == CNT_RST);
  assign cs_start_low = take && (new_cs_setup == CNT_RST);

  // ----------------------------------------------------------------
  // strobe generators
  // ----------------------------------------------------------------
  smc_edge_gen u_strobe (
    .clk       (clk),
    .rst       (rst),
    .active    (active),
    .last      (last),
    .cnt       (cnt_ff),
    .setup     (st_setup),
    .pulse     (st_pulse),
    .next_same (st_start_low),
    .strobe_n  (st_low_n),
    .rise      (st_rise)
  );

  smc_edge_gen u_select (
    .clk       (clk),
    .rst       (rst),
    .active    (active),
    .last      (last),
    .cnt       (cnt_ff),
    .setup     (cs_setup),
    .pulse     (cs_pulse),
    .next_same (cs_start_low),
    .strobe_n  (cs_low_n),
    .rise      (cs_rise)
  );

  // ----------------------------------------------------------------
  // state machine and counter
  // ----------------------------------------------------------------
  // the first strobe phase begins in cycle 0 when setup is null, so a new access
  // starts with counter 0 and the strobe flop is loaded from the lookahead
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    unique case (state_ff)
      SMC_IDLE: begin
        nxt_cnt = CNT_RST;
        if (take) begin
          nxt_state = req_write ? SMC_WRITE : SMC_READ;
        end
      end
      SMC_READ, SMC_WRITE: begin
        nxt_cnt = cnt_ff + 10'h001;
        if (last) begin
          nxt_cnt   = CNT_RST;
          nxt_state = take ? (req_write ? SMC_WRITE : SMC_READ) : SMC_IDLE;
        end
      end
      default: begin
        nxt_state = SMC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= SMC_IDLE;
      cnt_ff   <= CNT_RST;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // ----------------------------------------------------------------
  // address, byte selects and write data latch
  // ----------------------------------------------------------------
  // address bits below the bus width are forced low since the pins serve as strobes there
  logic [ADDR_W-1:0] nxt_addr;
  logic [1:0]        req_dbw;
  assign req_dbw  = bus_width[req_cs];
  assign nxt_addr = (req_dbw == DBW_32) ? {req_addr[ADDR_W-1:2], 2'h0} :
                    (req_dbw == DBW_16) ? {req_addr[ADDR_W-1:1], 1'h0} : req_addr;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_ff     <= 2'h0;
      wr_ff     <= 1'b0;
      ben_ff    <= 4'h0;
      addr_ff   <= {ADDR_W{1'b0}};
      wdata_ff  <= {DATA_W{1'b0}};
      bsel_n_ff <= 4'hF;
    end else if (take) begin
      cs_ff     <= req_cs;
      wr_ff     <= req_write;
      ben_ff    <= req_byte_en;
      addr_ff   <= nxt_addr;
      wdata_ff  <= req_wdata;
      // byte selects load in the same edge as the address
      bsel_n_ff <= ~req_byte_en;
    end else if (last) begin
      bsel_n_ff <= 4'hF;
    end
  end

  // ----------------------------------------------------------------
  // read capture and data drivers
  // ----------------------------------------------------------------
  logic capture, drive_on;
  // mode bit alone decides; the two waveforms are never compared
  assign capture  = (state_ff == SMC_READ) &&
                    (read_mode[cs_ff] ? st_rise : cs_rise);
  // drivers turn on from the controlling signal's setup and stay on to the end
  assign drive_on = (nxt_state == SMC_WRITE) &&
                    (take ? (write_mode[req_cs] ? st_start_low : cs_start_low)
                          : (nxt_cnt >= (write_mode[cs_ff] ? st_setup : cs_setup)));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff    <= {DATA_W{1'b0}};
      rd_valid_ff <= 1'b0;
      oe_ff       <= 1'b0;
    end else begin
      rd_valid_ff <= capture;
      oe_ff       <= drive_on;
      if (capture) begin
        rdata_ff <= mem_data_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin outputs
  // ----------------------------------------------------------------
  logic bw;
  assign bw = byte_write_mode[cs_ff];

  // chip select: one line per region, only the in-flight one follows the generator
  genvar g;
  generate
    for (g = 0; g < NUM_CS; g++) begin : g_cs
      assign chip_select_n[g] = (cs_ff == 2'(g)) ? cs_low_n : 1'b1;
    end
  endgenerate

  assign read_strobe_n  = wr_ff ? 1'b1 : st_low_n;
  assign write_strobe_n = (wr_ff && !bw) ? st_low_n : 1'b1;
  // byte writes copy the write strobe, gated per enabled byte
  assign byte0_write_strobe_n = (wr_ff && bw && ben_ff[0]) ? st_low_n : 1'b1;
  assign byte1_write_strobe_n = (wr_ff && bw && ben_ff[1]) ? st_low_n : 1'b1;
  assign byte2_write_strobe_n = (wr_ff && bw && ben_ff[2]) ? st_low_n : 1'b1;
  assign byte3_write_strobe_n = (wr_ff && bw && ben_ff[3]) ? st_low_n : 1'b1;
  assign byte0_select_n = bw ? 1'b1 : bsel_n_ff[0];
  assign byte1_select_n = bw ? 1'b1 : bsel_n_ff[1];
  assign byte2_select_n = bw ? 1'b1 : bsel_n_ff[2];
  assign byte3_select_n = bw ? 1'b1 : bsel_n_ff[3];
  assign mem_addr       = addr_ff;
  assign mem_data_out   = wdata_ff;
  assign mem_data_oe    = oe_ff;
  assign rd_valid       = rd_valid_ff;
  assign rd_data        = rdata_ff;

endmodule : smc_core

/* smc_core_sva.sv */
// ports-only checker of strobe, select, drive and capture timing
`timescale 1ns/1ps
module smc_sva
  import smc_pkg::*;
(
  // clock and reset
  input wire logic                    clk,
  input wire logic                    rst,
  // timing words and modes
  input wire logic [NUM_CS-1:0][23:0] setup_cfg,
  input wire logic [NUM_CS-1:0][27:0] pulse_cfg,
  input wire logic [NUM_CS-1:0][17:0] cycle_cfg,
  input wire logic [NUM_CS-1:0]       read_mode,
  input wire logic [NUM_CS-1:0]       write_mode,
  // request and answer
  input wire logic                    req_valid,
  input wire logic                    req_ready,
  input wire logic                    req_write,
  input wire logic [1:0]              req_cs,
  input wire logic                    rd_valid,
  // memory pins
  input wire logic [ADDR_W-1:0]       mem_addr,
  input wire logic [NUM_CS-1:0]       chip_select_n,
  input wire logic                    read_strobe_n,
  input wire logic                    write_strobe_n,
  input wire logic                    byte0_select_n,
  input wire logic                    byte1_select_n,
  input wire logic                    byte2_select_n,
  input wire logic                    byte3_select_n,
  input wire logic                    mem_data_oe
);
  // ----------------------------------------------------------------
  // access tracker and decoded windows
  // ----------------------------------------------------------------
  logic             on_ff;
  logic             wr_ff;
  logic [1:0]       cs_ff;
  logic [CNT_W-1:0] cnt_ff;
  wire              take = req_valid && req_ready;
  // counter restarts at each take so back-to-back accesses line up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      on_ff  <= 1'b0;
      wr_ff  <= 1'b0;
      cs_ff  <= 2'h0;
      cnt_ff <= CNT_RST;
    end else begin
      on_ff  <= take || (on_ff && !req_ready);
      wr_ff  <= take ? req_write : wr_ff;
      cs_ff  <= take ? req_cs : cs_ff;
      cnt_ff <= take ? CNT_RST : cnt_ff + 10'h001;
    end
  end
  function automatic int es(logic [5:0] v); return 128 * v[5] + v[4:0]; endfunction : es
  function automatic int ep(logic [6:0] v); return 256 * v[6] + v[5:0]; endfunction : ep
  function automatic int ec(logic [8:0] v); return 256 * v[8:7] + v[6:0]; endfunction : ec
  // live config is safe: the bench only rewrites it between accesses
  wire [31:0] n    = {22'h0, cnt_ff};
  wire [31:0] s_rd = es(setup_cfg[cs_ff][5:0]);
  wire [31:0] s_cr = es(setup_cfg[cs_ff][11:6]);
  wire [31:0] s_we = es(setup_cfg[cs_ff][17:12]);
  wire [31:0] s_cw = es(setup_cfg[cs_ff][23:18]);
  wire [31:0] e_rd = s_rd + ep(pulse_cfg[cs_ff][6:0]);
  wire [31:0] e_cr = s_cr + ep(pulse_cfg[cs_ff][13:7]);
  wire [31:0] e_we = s_we + ep(pulse_cfg[cs_ff][20:14]);
  wire [31:0] e_cw = s_cw + ep(pulse_cfg[cs_ff][27:21]);
  wire [31:0] tot  = wr_ff ? ec(cycle_cfg[cs_ff][17:9]) : ec(cycle_cfg[cs_ff][8:0]);
  wire [31:0] cap  = read_mode[cs_ff] ? e_rd : e_cr;
  wire [31:0] oe_s = write_mode[cs_ff] ? s_we : s_cw;
  wire        rd_on = on_ff && !wr_ff;
  wire        wr_on = on_ff && wr_ff;
  wire [3:0]  bs_n = {byte3_select_n, byte2_select_n, byte1_select_n, byte0_select_n};
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_rd_win; rd_on |-> read_strobe_n == !(n >= s_rd && n < e_rd); endproperty
  a_rd_win: assert property (p_rd_win) else $error("read strobe off its window");
  property p_rcs_win; rd_on |-> chip_select_n[cs_ff] == !(n >= s_cr && n < e_cr); endproperty
  a_rcs_win: assert property (p_rcs_win) else $error("read select off its window");
  property p_we_win; !write_strobe_n |-> wr_on && n >= s_we && n < e_we; endproperty
  a_we_win: assert property (p_we_win) else $error("write strobe low outside window");
  property p_wcs_win; wr_on |-> chip_select_n[cs_ff] == !(n >= s_cw && n < e_cw); endproperty
  a_wcs_win: assert property (p_wcs_win) else $error("write select off its window");
  property p_idle; !on_ff |-> &chip_select_n && read_strobe_n && write_strobe_n && !mem_data_oe && &bs_n; endproperty
  a_idle: assert property (p_idle) else $error("pins not at rest between accesses");
  property p_hold; on_ff && n != 0 |-> $stable(mem_addr) && $stable(bs_n); endproperty
  a_hold: assert property (p_hold) else $error("address or byte select moved mid access");
  property p_oe; wr_on |-> mem_data_oe == (n >= oe_s); endproperty
  a_oe: assert property (p_oe) else $error("data drive off its window");
  property p_ready; on_ff |-> req_ready == (n == tot - 1); endproperty
  a_ready: assert property (p_ready) else $error("access length wrong");
  property p_capture; rd_valid == $past(rd_on && n == cap - 1); endproperty
  a_capture: assert property (p_capture) else $error("read answer off the capture edge");
  c_b2b: cover property (on_ff && take);
  c_read: cover property (rd_valid);
  c_drive: cover property (wr_on && mem_data_oe);
endmodule : smc_sva

bind smc_core smc_sva chk_u (.clk, .rst, .setup_cfg, .pulse_cfg, .cycle_cfg, .read_mode, .write_mode,
  .req_valid, .req_ready, .req_write, .req_cs, .rd_valid, .mem_addr, .chip_select_n, .read_strobe_n,
  .write_strobe_n, .byte0_select_n, .byte1_select_n, .byte2_select_n, .byte3_select_n, .mem_data_oe);

/* smc_mem_model.sv */
// behavioural static memory: answers reads with an address pattern
`timescale 1ns/1ps
module smc_mem_model
  import smc_pkg::*;
(
  // clock
  input  wire logic                    clk,
  // memory pins
  input  wire logic [ADDR_W-1:0]       mem_addr,
  input  wire logic [NUM_CS-1:0]       chip_select_n,
  input  wire logic                    read_strobe_n,
  input  wire logic                    mem_data_oe,
  output logic [DATA_W-1:0]            mem_data_in
);
  logic [DATA_W-1:0] last_ff = 32'h0;
  // drive while the read strobe or any chip select is low and the bus is not driven; a released bus flips every cycle so late samples show
  wire act = !mem_data_oe && (!read_strobe_n || !(&chip_select_n));
  assign mem_data_in = act ? {mem_addr[7:0], 8'hA5, mem_addr[15:8] ^ 8'h3C, 8'h5A} : ~last_ff;
  // remember the bus for the released pattern
  always_ff @(posedge clk) last_ff <= mem_data_in;
endmodule : smc_mem_model

/* smc_core_tb.sv */
// self-checking bench for the static memory waveform generator
`timescale 1ns/1ps
module smc_core_tb;
  import smc_pkg::*;
  // ----------------------------------------------------------------
  // stimulus, design and memory
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [NUM_CS-1:0][23:0] setup_cfg;
  logic [NUM_CS-1:0][27:0] pulse_cfg;
  logic [NUM_CS-1:0][17:0] cycle_cfg;
  logic [NUM_CS-1:0][1:0]  bus_width;
  logic [NUM_CS-1:0]       read_mode, write_mode, byte_write_mode, chip_select_n;
  logic                    req_valid, req_ready, req_write, rd_valid, mem_data_oe, read_strobe_n, write_strobe_n;
  logic [1:0]              req_cs;
  logic [3:0]              req_byte_en, bw_n, bs_n;
  logic [ADDR_W-1:0]       req_addr, mem_addr;
  logic [DATA_W-1:0]       req_wdata, rd_data, mem_data_in, mem_data_out;
  logic [31:0]             seed = 32'h737867A9;
  int                      n_mismatch = 0;
  int                      checks_done = 0;
  smc_core dut_u (.clk, .rst, .setup_cfg, .pulse_cfg, .cycle_cfg, .read_mode, .write_mode, .byte_write_mode,
    .bus_width, .req_valid, .req_ready, .req_write, .req_cs, .req_addr, .req_byte_en, .req_wdata, .rd_valid,
    .rd_data, .mem_addr, .chip_select_n, .read_strobe_n, .write_strobe_n, .byte0_write_strobe_n(bw_n[0]),
    .byte1_write_strobe_n(bw_n[1]), .byte2_write_strobe_n(bw_n[2]), .byte3_write_strobe_n(bw_n[3]),
    .byte0_select_n(bs_n[0]), .byte1_select_n(bs_n[1]), .byte2_select_n(bs_n[2]), .byte3_select_n(bs_n[3]),
    .mem_data_in, .mem_data_out, .mem_data_oe);
  smc_mem_model mem_u (.clk, .mem_addr, .chip_select_n, .read_strobe_n, .mem_data_oe, .mem_data_in);
  always #12.5 clk = ~clk;
  function automatic int es(logic [5:0] v); return 128 * v[5] + v[4:0]; endfunction : es
  function automatic int ep(logic [6:0] v); return 256 * v[6] + v[5:0]; endfunction : ep
  function automatic int ec(logic [8:0] v); return 256 * v[8:7] + v[6:0]; endfunction : ec
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // random timing for one select; zero gives no setup, no hold and equal pulses
  task automatic rand_cfg(input int c, input logic zero);
    int s, p, q, mr, mw;
    q = 1 + $unsigned($random(seed)) % 4;
    mr = 0;
    mw = 0;
    for (int f = 0; f < 4; f++) begin
      s = zero ? 0 : $unsigned($random(seed)) % 4;
      p = zero ? q : 1 + $unsigned($random(seed)) % 4; // pulse kept at least one
      setup_cfg[c][6*f +: 6] = 6'(s);
      pulse_cfg[c][7*f +: 7] = 7'(p);
      if (f < 2) mr = (s + p > mr) ? s + p : mr;
      else mw = (s + p > mw) ? s + p : mw;
    end
    // totals never below setup plus pulse
    cycle_cfg[c] = {9'(mw + (zero ? 0 : $unsigned($random(seed)) % 3)), 9'(mr + (zero ? 0 : 1))};
    read_mode[c] = 1'($random(seed));
    write_mode[c] = 1'($random(seed));
    byte_write_mode[c] = 1'($random(seed));
    bus_width[c] = 2'($unsigned($random(seed)) % 3);
  endtask : rand_cfg
  // nreq back-to-back accesses of one kind; counts pin activity, called at a falling edge
  task automatic run(input int c, input logic w, input int nreq);
    int t, sp, pp, cp, os, g, lo_r, lo_c, lo_w, n_oe, n_v, f_r;
    t = w ? ec(cycle_cfg[c][17:9]) : ec(cycle_cfg[c][8:0]);
    sp = w ? es(setup_cfg[c][17:12]) : es(setup_cfg[c][5:0]);
    pp = w ? ep(pulse_cfg[c][20:14]) : ep(pulse_cfg[c][6:0]);
    cp = w ? ep(pulse_cfg[c][27:21]) : ep(pulse_cfg[c][13:7]);
    os = write_mode[c] ? sp : es(setup_cfg[c][23:18]);
    {lo_r, lo_c, lo_w, n_oe, n_v, f_r, g} = '0;
    req_cs = 2'(c);
    req_write = w;
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && g < 50) begin
      @(negedge clk);
      g++;
    end
    check(req_ready, 1'b1);
    for (int k = 1; k <= nreq * t + 1; k++) begin
      @(negedge clk);
      if (k == (nreq - 1) * t + 1) req_valid = 1'b0;
      lo_r += !read_strobe_n;
      lo_c += !chip_select_n[c];
      lo_w += (!write_strobe_n || !bw_n[0]);
      n_oe += mem_data_oe;
      if (f_r == 0 && !(read_strobe_n && write_strobe_n && bw_n[0])) f_r = k;
      if (rd_valid === 1'b1) begin
        n_v++;
        check(rd_data, {req_addr[7:0], 8'hA5, req_addr[15:8] ^ 8'h3C, 8'h5A});
      end
      if (k == 1) check(mem_addr[25:2], req_addr[25:2]);
      if (k == 1 && bus_width[c] == DBW_8) check(mem_addr, req_addr);
      if (mem_data_oe && bus_width[c] == DBW_32) check(mem_data_out, req_wdata);
      if (w && byte_write_mode[c] && bus_width[c] == DBW_32) check(bw_n, {4{bw_n[0]}});
    end
    check(lo_r, w ? 0 : nreq * pp);
    check(lo_c, nreq * cp);
    check(lo_w, w ? nreq * pp : 0);
    check(n_oe, w ? nreq * (t - os) : 0);
    check(n_v, w ? 0 : nreq);
    check(f_r, sp + 1);
  endtask : run
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    for (int c = 0; c < NUM_CS; c++) rand_cfg(c, 1'b0);
    {req_valid, req_write, req_cs, req_addr, req_wdata} = '0;
    req_byte_en = 4'hF;
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    check({&chip_select_n, read_strobe_n, write_strobe_n, &bs_n, mem_data_oe, rd_valid}, 6'h3C);
    $display("test reset done");
    setup_cfg[1] = {4{6'h21}};
    pulse_cfg[1] = {4{7'h41}};
    cycle_cfg[1] = {2{9'h183}};
    req_addr = 26'h2A5C3F4;
    run(1, 1'b0, 1);
    run(1, 1'b1, 1);
    $display("test wide fields done");
    for (int i = 0; i < 4; i++) begin
      rand_cfg(i, 1'b1);
      run(i, 1'($random(seed)), 2);
    end
    $display("test zero setup back to back done");
    for (int i = 0; i < 24; i++) begin
      req_cs = 2'($random(seed));
      rand_cfg(req_cs, 1'b0);
      req_addr = 26'($random(seed)) & 26'h3FFFFFC;
      req_wdata = $random(seed);
      run(req_cs, 1'($random(seed)), 1 + $unsigned($random(seed)) % 2);
    end
    $display("test random accesses done");
    conclude();
  end
  // cut a hang short well beyond the expected run length
  initial begin
    #500000;
    n_mismatch++;
    conclude();
  end
endmodule : smc_core_tb
